// *** logic/fis_core.sv ***
// Fragment input setup: derives per-fragment shader inputs, AHB-Lite registers
module fis_core
#(
   parameter int MAX_SAMPLES = 8,
   parameter int SAMPLE_W    = 3,
   parameter int MASK_WORDS  = 1
)
(
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic      [31:0]               hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   input  wire logic                      frag_valid,
   output logic                           frag_ready,
   input  wire logic [31:0]               win_x,
   input  wire logic [31:0]               win_y,
   input  wire logic [31:0]               win_z,
   input  wire logic [31:0]               clip_w,
   input  wire logic [255:0]              colour_in,
   input  wire logic                      colour_is_float,
   input  wire fis_pkg::fis_prim_t        prim_class,
   input  wire logic [31:0]               signed_area,
   input  wire logic [31:0]               gs_prim_id,
   input  wire logic [MAX_SAMPLES-1:0]    cov_mask,
   input  wire logic [MAX_SAMPLES-1:0]    discard_mask,
   input  wire logic [SAMPLE_W-1:0]       sample_index,
   input  wire logic                      per_sample_qual,
   input  wire logic                      reads_sample_id,
   input  wire logic                      reads_sample_pos,
   input  wire logic [1:0]                invocation_index,
   input  wire logic                      prim_begin,
   input  wire logic                      prim_end,
   input  wire logic                      prim_end_last,
   output logic                           out_valid,
   input  wire logic                      out_ready,
   output logic      [31:0]               fragment_coordinate_x,
   output logic      [31:0]               fragment_coordinate_y,
   output logic      [31:0]               fragment_coordinate_z,
   output logic      [31:0]               fragment_coordinate_w,
   output logic      [127:0]              primary_colour_input,
   output logic      [127:0]              secondary_colour_input,
   output logic                           front_facing_flag,
   output logic      [31:0]               primitive_identifier,
   output logic      [MASK_WORDS*32-1:0]  covered_sample_mask,
   output logic      [SAMPLE_W-1:0]       sample_number,
   output logic      [7:0]                sample_count,
   output logic      [4:0]                sample_subpixel_position_x,
   output logic      [4:0]                sample_subpixel_position_y,
   output logic                           per_sample_eval
);
   import fis_pkg::*;

   localparam int MW = MASK_WORDS * 32;

   typedef struct packed {
      logic [CTRL_W-1:0]   ctrl;
      logic [15:0]         height;
      logic [7:0]          samples;
      logic [1:0]          invoc;
      logic                wr_pend;
      logic [7:0]          wr_addr;
      logic [31:0]         hrdata;
      logic                hready;
      fis_state_t          st;
      logic                in_ready;
      logic [5:0]          div_cnt;
      logic [32:0]         div_rem;
      logic [32:0]         div_q;
      logic [31:0]         div_den;
      logic                w_neg;
      logic [31:0]         prim_cnt;
      logic                out_valid;
      logic [31:0]         frag_x;
      logic [31:0]         frag_y;
      logic [31:0]         frag_z;
      logic [31:0]         frag_w;
      logic [255:0]        colour;
      logic                front;
      logic [31:0]         prim_id;
      logic [MW-1:0]       mask;
      logic [SAMPLE_W-1:0] sample_num;
      logic [4:0]          pos_x;
      logic [4:0]          pos_y;
      logic                per_sample;
   } fis_regs_t;

   fis_regs_t q;
   fis_regs_t d;

   // Unorm8 to float32; end points forced so that 0 and 1 stay exact
   function automatic logic [31:0] fis_unorm_to_f32(input logic [7:0] c);
      logic [23:0] f;
      logic [4:0]  p;
      logic [23:0] sh;
      f  = 24'(c) * 24'(UNORM_RECIP); // Widen first: the full product needs 24 bits
      p  = 5'h00;
      for (int i = 0; i < 24; i++)
      begin
         if (f[i])
            p = 5'(i);
      end
      sh = f << (5'h17 - p);
      if (c == 8'h00)
         return 32'h0000_0000;
      if (c == UNORM_MAX)
         return ONE_F32;
      return {1'b0, 8'(F32_EXP_BASE + 8'(p)), sh[22:0]};
   endfunction

   logic [255:0]         colour_cvt;
   logic [MAX_SAMPLES-1:0] owned;
   logic [MAX_SAMPLES-1:0] kept_cov;
   logic [1:0]           inv_msk;
   logic                 ms_active;
   logic                 per_sample;
   logic [MW-1:0]        mask_next;
   logic [31:0]          x_next;
   logic [31:0]          y_pre;
   logic [31:0]          y_next;
   logic                 ff_next;
   logic [32:0]          rem_sh;
   logic                 div_ge;
   logic [32:0]          rem_nx;
   logic [32:0]          q_nx;
   logic [31:0]          w_mag;
   logic [31:0]          w_res;
   logic                 take;

   // Colour conversion per component; float inputs bypass it
   for (genvar i = 0; i < 8; i++)
   begin : g_col
      assign colour_cvt[i*32 +: 32] = colour_is_float ? colour_in[i*32 +: 32] :
                                      fis_unorm_to_f32(colour_in[i*32 +: 8]);
   end

   // Sample ownership: one invocation per sample, or just the current sample
   for (genvar i = 0; i < MAX_SAMPLES; i++)
   begin : g_own
      assign owned[i] = per_sample ? (sample_index == SAMPLE_W'(i)) :
                        ((2'(i) & inv_msk) == (invocation_index & inv_msk));
   end

   // Multisampling only counts when the target has more than one sample
   assign ms_active  = (q.samples > SAMPLES_RST) && q.ctrl[CTRL_MS_EN];
   assign per_sample = per_sample_qual | reads_sample_id | reads_sample_pos;
   assign inv_msk    = 2'((3'h1 << q.invoc) - 3'h1);
   assign kept_cov   = cov_mask & ~discard_mask;
   assign mask_next  = ms_active ? MW'(kept_cov & owned) : MW'(kept_cov[0]);

   // Coordinate conventions; control reset value selects half-integer, lower-left
   assign x_next = q.ctrl[CTRL_CENTRE_INT] ? win_x - HALF_Q16 : win_x;
   assign y_pre  = q.ctrl[CTRL_ORIGIN_UL] ? {q.height, 16'h0000} - win_y : win_y;
   assign y_next = q.ctrl[CTRL_CENTRE_INT] ? y_pre - HALF_Q16 : y_pre;

   // Facing: reversal flips which sign counts as front
   assign ff_next = (prim_class != FIS_PRIM_POLY) ? 1'b1 :
                    q.ctrl[CTRL_WIND_REV] ? signed_area[31] :
                    ($signed(signed_area) > 32'sh0);

   // One restoring step of 2^32 / |w|; slow but small, no multiplier needed
   assign rem_sh = {q.div_rem[31:0], q.div_cnt == DIV_LAST};
   assign div_ge = rem_sh >= {1'b0, q.div_den};
   assign rem_nx = div_ge ? rem_sh - {1'b0, q.div_den} : rem_sh;
   assign q_nx   = {q.div_q[31:0], div_ge};
   assign w_mag  = (q_nx[32] || q_nx[31]) ? SAT_Q16 : q_nx[31:0];
   assign w_res  = q.w_neg ? 32'(-w_mag) : w_mag;

   assign take = (q.st == FIS_IDLE) && q.in_ready && frag_valid;

   // Next-state logic for bus, counter and fragment pipeline
   always_comb
   begin
      d         = q;
      d.hrdata  = 32'h0000_0000;
      d.wr_pend = 1'b0;
      d.hready  = 1'b1;
      // Address phase: reads answered from flops in the data phase
      if (hsel && hready && htrans[1])
      begin
         d.wr_pend = hwrite;
         d.wr_addr = haddr[7:0];
         if (!hwrite)
         begin
            case (haddr[7:0])
               ADDR_CTRL:    d.hrdata = 32'(q.ctrl);
               ADDR_HEIGHT:  d.hrdata = 32'(q.height);
               ADDR_SAMPLES: d.hrdata = 32'(q.samples);
               ADDR_INVOC:   d.hrdata = 32'(q.invoc);
               ADDR_STATUS:  d.hrdata = q.prim_cnt;
               default:      d.hrdata = 32'h0000_0000;
            endcase
         end
      end
      // Data phase of a write
      if (q.wr_pend)
      begin
         case (q.wr_addr)
            ADDR_CTRL:    d.ctrl    = hwdata[CTRL_W-1:0];
            ADDR_HEIGHT:  d.height  = hwdata[15:0];
            ADDR_SAMPLES: d.samples = hwdata[7:0];
            ADDR_INVOC:   d.invoc   = hwdata[1:0];
            default:      d.wr_pend = 1'b0;
         endcase
      end
      // Counter: begin wins; partial pieces and restarts leave it alone
      if (prim_begin)
         d.prim_cnt = 32'h0000_0000;
      else if (prim_end && prim_end_last && !q.ctrl[CTRL_GEOM_ACT])
         d.prim_cnt = q.prim_cnt + 32'h0000_0001;
      // Fragment pipeline
      unique case (q.st)
         FIS_IDLE:
         begin
            if (take)
            begin
               d.st         = FIS_DIV;
               d.in_ready   = 1'b0;
               d.div_cnt    = DIV_LAST;
               d.div_rem    = 33'h0_0000_0000;
               d.div_q      = 33'h0_0000_0000;
               d.div_den    = clip_w[31] ? 32'(-clip_w) : clip_w;
               d.w_neg      = clip_w[31];
               d.frag_x     = x_next;
               d.frag_y     = y_next;
               d.frag_z     = win_z;
               d.colour     = colour_cvt;
               d.front      = ff_next;
               d.prim_id    = q.ctrl[CTRL_GEOM_ACT] ? gs_prim_id : q.prim_cnt;
               d.mask       = mask_next;
               d.sample_num = ms_active ? sample_index : '0;
               d.pos_x      = ms_active ? POS_X_TAB[3'(sample_index)] : POS_CENTRE;
               d.pos_y      = ms_active ? POS_Y_TAB[3'(sample_index)] : POS_CENTRE;
               d.per_sample = per_sample;
            end
         end
         FIS_DIV:
         begin
            d.div_rem = rem_nx;
            d.div_q   = q_nx;
            if (q.div_cnt == 6'h00)
            begin
               d.st        = FIS_OUT;
               d.out_valid = 1'b1;
               d.frag_w    = w_res;
            end
            else
               d.div_cnt = q.div_cnt - 6'h01;
         end
         FIS_OUT:
         begin
            // Everything holds until the shader core takes it
            if (out_ready)
            begin
               d.out_valid = 1'b0;
               d.st        = FIS_IDLE;
               d.in_ready  = 1'b1;
            end
         end
         default:
            d.st = FIS_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q          <= '0;
         q.ctrl     <= CTRL_RST;
         q.height   <= HEIGHT_RST;
         q.samples  <= SAMPLES_RST;
         q.invoc    <= INVOC_RST;
         q.hready   <= 1'b1;
         q.st       <= FIS_IDLE;
         q.in_ready <= 1'b1;
         q.pos_x    <= POS_CENTRE;
         q.pos_y    <= POS_CENTRE;
      end
      else
         q <= d;
   end

   // Outputs straight from flops
   assign hrdata                     = q.hrdata;
   assign hreadyout                  = q.hready;
   assign hresp                      = q.wr_pend & 1'b0;
   assign frag_ready                 = q.in_ready;
   assign out_valid                  = q.out_valid;
   assign fragment_coordinate_x      = q.frag_x;
   assign fragment_coordinate_y      = q.frag_y;
   assign fragment_coordinate_z      = q.frag_z;
   assign fragment_coordinate_w      = q.frag_w;
   assign primary_colour_input       = q.colour[127:0];
   assign secondary_colour_input     = q.colour[255:128];
   assign front_facing_flag          = q.front;
   assign primitive_identifier       = q.prim_id;
   assign covered_sample_mask        = q.mask;
   assign sample_number              = q.sample_num;
   assign sample_count               = q.samples;
   assign sample_subpixel_position_x = q.pos_x;
   assign sample_subpixel_position_y = q.pos_y;
   assign per_sample_eval            = q.per_sample;

   default clocking fis_cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_x_centre: assert property (take |=> q.frag_x == ($past(q.ctrl[CTRL_CENTRE_INT]) ?
                                  $past(win_x) - HALF_Q16 : $past(win_x)))
      else $error("fragment x wrong for centre convention");
   chk_y_flip: assert property (take && q.ctrl[CTRL_ORIGIN_UL] && !q.ctrl[CTRL_CENTRE_INT] |=>
                                q.frag_y == {$past(q.height), 16'h0000} - $past(win_y))
      else $error("fragment y not flipped");
   chk_conv_default: assert property (take && q.ctrl == CTRL_RST |=>
                                      q.frag_x == $past(win_x) && q.frag_y == $past(win_y))
      else $error("default conventions not applied");
   chk_z_pass: assert property (take |=> q.frag_z == $past(win_z))
      else $error("depth not passed through");
   chk_w_timing: assert property (take |-> ##33 !q.out_valid ##1 q.out_valid)
      else $error("reciprocal not ready after 34 cycles");
   chk_w_unit: assert property (take && clip_w == ONE_Q16 |-> ##34 q.frag_w == ONE_Q16)
      else $error("reciprocal of one is not one");
   chk_colour_one: assert property (take && !colour_is_float && colour_in[7:0] == UNORM_MAX |=>
                                    q.colour[31:0] == ONE_F32)
      else $error("unorm one not exact");
   chk_face_other: assert property (take && prim_class != FIS_PRIM_POLY |=> q.front)
      else $error("non-polygon fragment not front-facing");
   chk_face_area: assert property (take && prim_class == FIS_PRIM_POLY && !q.ctrl[CTRL_WIND_REV]
                                   && signed_area[31] |=> !q.front)
      else $error("negative area reported front-facing");
   chk_prim_begin: assert property (prim_begin |=> q.prim_cnt == 32'h0000_0000)
      else $error("counter not cleared at begin");
   chk_prim_piece: assert property (prim_end && !prim_end_last && !prim_begin |=> $stable(q.prim_cnt))
      else $error("counter moved on a partial primitive");
   chk_mask_single: assert property (take && !ms_active |=> q.mask[MW-1:1] == '0)
      else $error("extra mask bits without multisampling");
   chk_sample_zero: assert property (take && !ms_active |=>
                                     q.sample_num == '0 && q.pos_x == POS_CENTRE)
      else $error("sample number or position not neutral");
   chk_hold_out: assert property (q.out_valid && !out_ready |=> q.out_valid && $stable(q.frag_x))
      else $error("output dropped before acceptance");

   cov_ms_frag: cover property (take && ms_active && !per_sample);
   cov_per_sample: cover property (take && ms_active && per_sample);
   cov_geom: cover property (take && q.ctrl[CTRL_GEOM_ACT]);
   cov_stall: cover property (q.out_valid && !out_ready ##1 out_ready);

endmodule

// *** pkg/fis_pkg.sv ***
// Constants and types for the fragment input setup block
package fis_pkg;

   // Register byte offsets
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_HEIGHT     = 8'h04;
   localparam logic [7:0]  ADDR_SAMPLES    = 8'h08;
   localparam logic [7:0]  ADDR_INVOC      = 8'h0c;
   localparam logic [7:0]  ADDR_STATUS     = 8'h10;

   // Control register fields
   localparam int          CTRL_CENTRE_INT = 0;
   localparam int          CTRL_ORIGIN_UL  = 1;
   localparam int          CTRL_WIND_REV   = 2;
   localparam int          CTRL_MS_EN      = 3;
   localparam int          CTRL_GEOM_ACT   = 4;
   localparam int          CTRL_W          = 5;

   // Reset values
   localparam logic [4:0]  CTRL_RST        = 5'h00;
   localparam logic [15:0] HEIGHT_RST      = 16'h0000;
   localparam logic [7:0]  SAMPLES_RST     = 8'h01;
   localparam logic [1:0]  INVOC_RST       = 2'h0;

   // Number formats: coordinates are Q16.16, colours float32
   localparam logic [31:0] HALF_Q16        = 32'h0000_8000;
   localparam logic [31:0] ONE_Q16         = 32'h0001_0000;
   localparam logic [31:0] ONE_F32         = 32'h3f80_0000;
   localparam logic [31:0] SAT_Q16         = 32'h7fff_ffff;
   localparam logic [7:0]  UNORM_MAX       = 8'hff;
   localparam logic [16:0] UNORM_RECIP     = 17'h1_0101;
   localparam logic [7:0]  F32_EXP_BASE    = 8'h67;

   // Reciprocal divider: 33 restoring steps on 2^32
   localparam logic [5:0]  DIV_LAST        = 6'h20;

   // Sub-pixel positions in sixteenths, centre at 8
   localparam logic [4:0]  POS_CENTRE      = 5'h08;
   localparam logic [7:0][4:0] POS_X_TAB   = {5'h0f, 5'h01, 5'h0b, 5'h03, 5'h05, 5'h0d, 5'h07, 5'h09};
   localparam logic [7:0][4:0] POS_Y_TAB   = {5'h01, 5'h0f, 5'h07, 5'h0d, 5'h03, 5'h09, 5'h0b, 5'h05};

   typedef enum logic [1:0] {
      FIS_PRIM_POINT = 2'b00,
      FIS_PRIM_LINE  = 2'b01,
      FIS_PRIM_POLY  = 2'b10,
      FIS_PRIM_RECT  = 2'b11
   } fis_prim_t;

   typedef enum logic [1:0] {
      FIS_IDLE = 2'b00,
      FIS_DIV  = 2'b01,
      FIS_OUT  = 2'b10
   } fis_state_t;

endpackage

// *** tb/fis_sink.sv ***
// Shader core model that takes setup results after a chosen delay
module fis_sink
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       out_valid,
   input  wire logic [3:0] lat,
   output logic            out_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_q;
   // Ready only after valid has stood lat cycles, so held outputs get looked at
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wait_q    <= 4'h0;
         out_ready <= 1'b0;
      end
      else if (out_ready && out_valid)
      begin
         wait_q    <= 4'h0;
         out_ready <= 1'b0;
      end
      else if (out_valid)
      begin
         wait_q    <= wait_q + 4'h1;
         out_ready <= (wait_q >= lat);
      end
   end
endmodule

// *** tb/fis_core_test.sv ***
// Self-checking bench for the fragment input setup block
module fis_core_test;
   import fis_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, frag_valid, frag_ready, colour_is_float;
   logic per_sample_qual, reads_sample_id, reads_sample_pos, prim_begin, prim_end, prim_end_last;
   logic out_valid, out_ready, front_facing_flag, per_sample_eval;
   logic [31:0] haddr, hwdata, hrdata, win_x, win_y, win_z, clip_w, signed_area, gs_prim_id, rd;
   logic [31:0] fragment_coordinate_x, fragment_coordinate_y, fragment_coordinate_z, fragment_coordinate_w;
   logic [31:0] primitive_identifier, covered_sample_mask;
   logic [255:0] colour_in;
   logic [127:0] primary_colour_input, secondary_colour_input;
   logic [1:0] htrans, invocation_index;
   logic [2:0] hsize, sample_index, sample_number;
   logic [7:0] cov_mask, discard_mask, sample_count;
   logic [4:0] sample_subpixel_position_x, sample_subpixel_position_y;
   logic [3:0] lat;
   fis_prim_t prim_class;
   int n_fail, check_count, cycles;
   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;
   fis_core i_dut (.*);
   fis_sink i_sink (.hclk(hclk), .hresetn(hresetn), .out_valid(out_valid), .lat(lat), .out_ready(out_ready));
   // 25 MHz clock
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // Hang guard, far above the thousand or so cycles the tests need
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One single AHB transfer; read data lands in rd
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // Offer one fragment and wait for its results; the previous one must be gone first
   task automatic frag();
      int i;
      while (out_valid === 1'b1) @(posedge hclk);
      @(posedge hclk);
      frag_valid <= 1'b1;
      do @(posedge hclk); while (frag_ready !== 1'b1);
      frag_valid <= 1'b0;
      for (i = 0; i < 60 && out_valid !== 1'b1; i++) @(posedge hclk);
      chk("valid", 1'b1, out_valid);
      chk("busy", 1'b0, frag_ready);
   endtask
   task automatic pulse(input logic b, input logic e, input logic l);
      @(posedge hclk);
      {prim_begin, prim_end, prim_end_last} <= {b, e, l};
      @(posedge hclk);
      {prim_begin, prim_end, prim_end_last} <= 3'h0;
   endtask
   task automatic t_regs();
      chk("count at reset", 8'h01, sample_count);
      chk("pos at reset", {POS_CENTRE, POS_CENTRE}, {sample_subpixel_position_x, sample_subpixel_position_y});
      bus(ADDR_SAMPLES, 1'b0, 32'h0);
      chk("samples reg", {24'h0, SAMPLES_RST}, rd);
      chk("hresp", 1'b0, hresp);
      bus(ADDR_CTRL, 1'b0, 32'h0);
      chk("ctrl reg", {27'h0, CTRL_RST}, rd);
      bus(8'h20, 1'b1, 32'h5a5a_5a5a);
      bus(8'h20, 1'b0, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("test regs done");
   endtask
   task automatic t_coord();
      int c;
      logic [31:0] ey;
      bus(ADDR_HEIGHT, 1'b1, 32'h0000_000a);
      {win_x, win_y, win_z, clip_w} <= {32'h0005_0000, 32'h0003_0000, ONE_F32, 32'h0002_0000};
      for (c = 0; c < 4; c++)
      begin
         bus(ADDR_CTRL, 1'b1, 32'(c));
         frag();
         ey = (c[1] ? 32'h0007_0000 : 32'h0003_0000) - (c[0] ? HALF_Q16 : 32'h0);
         chk("coord x", c[0] ? 32'h0004_8000 : 32'h0005_0000, fragment_coordinate_x);
         chk("coord y", ey, fragment_coordinate_y);
         chk("coord z", ONE_F32, fragment_coordinate_z);
         chk("coord w", 32'h0000_8000, fragment_coordinate_w);
      end
      {win_z, clip_w} <= {32'h0, 32'hfffe_0000};
      frag();
      chk("coord z", 32'h0, fragment_coordinate_z);
      chk("coord w", 32'hffff_8000, fragment_coordinate_w);
      $display("test coord done");
   endtask
   task automatic t_colour();
      // Slow shader core: results must hold while waiting
      lat <= 4'h6;
      colour_in <= {{4{32'h0000_00ff}}, {4{32'h0}}};
      frag();
      chk("primary", 128'h0, primary_colour_input);
      chk("secondary", {4{ONE_F32}}, secondary_colour_input);
      {colour_is_float, colour_in} <= {1'b1, {8{32'h4040_0000}}};
      frag();
      repeat (4) @(posedge hclk);
      chk("float held", {4{32'h4040_0000}}, primary_colour_input);
      colour_is_float <= 1'b0;
      lat <= 4'h1;
      $display("test colour done");
   endtask
   task automatic t_facing();
      int i;
      logic [31:0] ar [7];
      ar = '{32'h10, 32'hffff_fff0, 32'h0, 32'hffff_fff0, 32'h10, 32'hffff_fff0, 32'hffff_fff0};
      for (i = 0; i < 7; i++)
      begin
         bus(ADDR_CTRL, 1'b1, (i == 3 || i == 4) ? 32'h4 : 32'h0);
         signed_area <= ar[i];
         prim_class <= (i == 5) ? FIS_PRIM_LINE : (i == 6) ? FIS_PRIM_POINT : FIS_PRIM_POLY;
         frag();
         chk("facing", (i == 0 || i == 3 || i > 4) ? 1'b1 : 1'b0, front_facing_flag);
      end
      $display("test facing done");
   endtask
   task automatic t_primid();
      bus(ADDR_CTRL, 1'b1, 32'h0);
      pulse(1'b1, 1'b0, 1'b0);
      frag();
      chk("prim id", 32'h0, primitive_identifier);
      pulse(1'b0, 1'b1, 1'b0);
      pulse(1'b0, 1'b1, 1'b0);
      bus(ADDR_STATUS, 1'b0, 32'h0);
      chk("counter", 32'h0, rd);
      pulse(1'b0, 1'b1, 1'b1);
      pulse(1'b0, 1'b1, 1'b1);
      frag();
      chk("prim id", 32'h2, primitive_identifier);
      pulse(1'b1, 1'b1, 1'b1);
      bus(ADDR_STATUS, 1'b0, 32'h0);
      chk("counter", 32'h0, rd);
      bus(ADDR_CTRL, 1'b1, 32'h10);
      gs_prim_id <= 32'h0000_abcd;
      frag();
      chk("geom id", 32'h0000_abcd, primitive_identifier);
      $display("test primid done");
   endtask
   task automatic t_sample();
      bus(ADDR_SAMPLES, 1'b1, 32'h4);
      bus(ADDR_CTRL, 1'b1, 32'h8);
      {cov_mask, discard_mask, sample_index} <= {8'h0f, 8'h02, 3'h1};
      frag();
      chk("mask", 32'h0d, covered_sample_mask);
      chk("count", 8'h04, sample_count);
      bus(ADDR_INVOC, 1'b1, 32'h1);
      invocation_index <= 2'h1;
      frag();
      chk("mask", 32'h08, covered_sample_mask);
      bus(ADDR_INVOC, 1'b1, 32'h0);
      {per_sample_qual, sample_index} <= {1'b1, 3'h2};
      frag();
      chk("mask", 32'h04, covered_sample_mask);
      chk("number", 3'h2, sample_number);
      chk("pos", {5'h0d, 5'h09}, {sample_subpixel_position_x, sample_subpixel_position_y});
      {per_sample_qual, reads_sample_pos, discard_mask} <= {1'b0, 1'b1, 8'h0};
      frag();
      chk("per sample", 1'b1, per_sample_eval);
      chk("mask", 32'h04, covered_sample_mask);
      {reads_sample_pos, reads_sample_id, sample_index} <= {1'b0, 1'b1, 3'h3};
      frag();
      chk("mask", 32'h08, covered_sample_mask);
      chk("number", 3'h3, sample_number);
      bus(ADDR_CTRL, 1'b1, 32'h0);
      frag();
      chk("mask", 32'h01, covered_sample_mask);
      chk("number", 3'h0, sample_number);
      chk("pos", {POS_CENTRE, POS_CENTRE}, {sample_subpixel_position_x, sample_subpixel_position_y});
      chk("count", 8'h04, sample_count);
      $display("test sample done");
   endtask
   // Reset, then the scenarios in turn
   initial
   begin
      {hresetn, hsel, hwrite, frag_valid, colour_is_float, per_sample_qual, reads_sample_id} = 7'h0;
      {reads_sample_pos, prim_begin, prim_end, prim_end_last, htrans, invocation_index, sample_index} = 11'h0;
      {haddr, hwdata, win_x, win_y, win_z, clip_w, signed_area, gs_prim_id} = 256'h0;
      {colour_in, cov_mask, discard_mask} = 272'h0;
      {hsize, lat, prim_class} = {3'h2, 4'h1, FIS_PRIM_POINT};
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_coord();
      t_colour();
      t_facing();
      t_primid();
      t_sample();
      stop_test();
   end
endmodule
